// file: shared/gpibcp_pkg.sv
package gpibcp_pkg;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int unsigned CLK_HZ          = 20000000;
    localparam int unsigned SETTLE_NS       = 500;
    localparam int unsigned SETTLE_CYC      = (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned IFC_US          = 100;
    localparam int unsigned IFC_CYC         = IFC_US * (CLK_HZ / 1000000);
    localparam int unsigned CNT_W           = 12;

    // ==========================================================
    // byte layout
    // ==========================================================
    localparam int unsigned DATA_W          = 8;
    localparam int unsigned MSB_POS         = 7;

    typedef enum logic [2:0] {
        GPIBCP_IDLE,
        GPIBCP_T_SETTLE,
        GPIBCP_T_DAV,
        GPIBCP_T_REL,
        GPIBCP_L_READY,
        GPIBCP_L_ACCEPT,
        GPIBCP_L_WAIT,
        GPIBCP_IFC
    } gpibcp_state_e;

endpackage

// file: core/gpibcp_port.sv
// Summary of operation
// - data lines are two-way, active low, and line eight carries bit seven of each byte.
// - bytes move eight bits in parallel, one after another under the handshake.
// - the controller alone drives attention while it addresses talkers and listeners.
// - the controller alone drives interface clear so every instrument resets.
// - while remote enable is asserted instruments obey only the bus.
// - a talker may mark the last byte with end-or-identify; with attention it runs a poll.
// - not-ready-for-data goes high only when all listeners release it, then a byte may go out.
// - the talker pulls data-valid low after the byte settles and listeners capture it then.
// - the talker never asserts data-valid while not-ready-for-data is low.
// - not-data-accepted going high tells the talker the byte is complete.
`timescale 1ns/1ns
`default_nettype none

module gpibcp_port (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // user side
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_cmd_i,
    input  wire logic       tx_end_i,
    input  wire logic       rx_start_i,
    output logic            rx_valid_o,
    output logic [7:0]      rx_data_o,
    output logic            rx_end_o,
    input  wire logic       rx_ready_i,
    input  wire logic       ifc_req_i,
    input  wire logic       remote_i,
    input  wire logic       poll_i,
    output logic            srq_o,
    output logic            busy_o,
    // bus side, levels are true electrical levels
    input  wire logic [7:0] dio_i,
    output logic [7:0]      dio_o,
    output logic [7:0]      dio_oe_o,
    input  wire logic       dav_i,
    output logic            dav_oe_o,
    input  wire logic       nrfd_i,
    output logic            nrfd_oe_o,
    input  wire logic       ndac_i,
    output logic            ndac_oe_o,
    input  wire logic       eoi_i,
    output logic            eoi_oe_o,
    output logic            atn_oe_o,
    output logic            ifc_oe_o,
    output logic            ren_oe_o,
    input  wire logic       srq_i
);

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        gpibcp_pkg::gpibcp_state_e st;
        logic [gpibcp_pkg::CNT_W-1:0] cnt;
        logic [7:0] txb;
        logic       txeoi;
        logic       atn;
        logic       rxv;
        logic [7:0] rxb;
        logic       rxe;
        logic       srq;
    } gpibcp_s;

    gpibcp_s s_q;
    gpibcp_s s_d;

    // ==========================================================
    // next state
    // ==========================================================
    always_comb begin
        s_d = s_q;
        s_d.srq = ~srq_i;
        if (rx_valid_o && rx_ready_i) begin
            s_d.rxv = 1'b0;
        end
        case (s_q.st)
            gpibcp_pkg::GPIBCP_IDLE: begin
                if (ifc_req_i) begin
                    s_d.st  = gpibcp_pkg::GPIBCP_IFC;
                    s_d.cnt = '0;
                end else if (tx_valid_i) begin
                    s_d.txb   = tx_data_i;
                    s_d.txeoi = tx_end_i;
                    s_d.atn   = tx_cmd_i;
                    s_d.cnt   = '0;
                    s_d.st    = gpibcp_pkg::GPIBCP_T_SETTLE;
                end else if (rx_start_i && !s_q.rxv) begin
                    s_d.atn = 1'b0;
                    s_d.st  = gpibcp_pkg::GPIBCP_L_READY;
                end
            end
            gpibcp_pkg::GPIBCP_T_SETTLE: begin
                // byte goes out only once every listener has let go of
                // not-ready; a listener that pulls it again withdraws the
                // byte and restarts the settle count
                // cnt 0 means not yet released, then it counts settle cycles
                if (!nrfd_i) begin
                    s_d.cnt = '0;
                end else if (s_q.cnt >= gpibcp_pkg::CNT_W'(gpibcp_pkg::SETTLE_CYC)) begin
                    s_d.st = gpibcp_pkg::GPIBCP_T_DAV;
                end else begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
            end
            gpibcp_pkg::GPIBCP_T_DAV: begin
                if (ndac_i) begin
                    s_d.st = gpibcp_pkg::GPIBCP_T_REL;
                end
            end
            gpibcp_pkg::GPIBCP_T_REL: begin
                // hold off next byte until listeners re-arm not-accepted
                if (!ndac_i) begin
                    s_d.st = gpibcp_pkg::GPIBCP_IDLE;
                end
            end
            gpibcp_pkg::GPIBCP_L_READY: begin
                // we act as acceptor; released ready only when buffer free
                if (!dav_i) begin
                    s_d.rxb = ~dio_i;
                    s_d.rxe = ~eoi_i;
                    s_d.st  = gpibcp_pkg::GPIBCP_L_ACCEPT;
                end
            end
            gpibcp_pkg::GPIBCP_L_ACCEPT: begin
                s_d.rxv = 1'b1;
                s_d.st  = gpibcp_pkg::GPIBCP_L_WAIT;
            end
            gpibcp_pkg::GPIBCP_L_WAIT: begin
                if (dav_i) begin
                    s_d.st = gpibcp_pkg::GPIBCP_IDLE;
                end
            end
            gpibcp_pkg::GPIBCP_IFC: begin
                s_d.atn = 1'b0;
                if (s_q.cnt >= gpibcp_pkg::CNT_W'(gpibcp_pkg::IFC_CYC - 1)) begin
                    s_d.st = gpibcp_pkg::GPIBCP_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
            end
            default: begin
                s_d.st = gpibcp_pkg::GPIBCP_IDLE;
            end
        endcase
        if (reset_i) begin
            s_d     = '0;
            s_d.st  = gpibcp_pkg::GPIBCP_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    // ==========================================================
    // decode
    // ==========================================================
    // talker role runs from taking the byte to releasing data-valid;
    // attention and end marking follow the role, not the data lines
    function automatic logic is_talker(input gpibcp_pkg::gpibcp_state_e st);
        return (st == gpibcp_pkg::GPIBCP_T_SETTLE) ||
               (st == gpibcp_pkg::GPIBCP_T_DAV);
    endfunction

    // not-ready is let go while listening for a byte and while talking,
    // so that only the instruments decide when the next byte may go
    function automatic logic frees_nrfd(input gpibcp_pkg::gpibcp_state_e st);
        return (st == gpibcp_pkg::GPIBCP_L_READY) ||
               (st == gpibcp_pkg::GPIBCP_T_SETTLE) ||
               (st == gpibcp_pkg::GPIBCP_T_DAV) ||
               (st == gpibcp_pkg::GPIBCP_T_REL);
    endfunction

    // not-accepted is held while idle or waiting for a byte; it drops
    // once the byte sits in the receive register when listening, and on leaving idle to talk or clear
    function automatic logic holds_ndac(input gpibcp_pkg::gpibcp_state_e st);
        return (st == gpibcp_pkg::GPIBCP_L_READY) ||
               (st == gpibcp_pkg::GPIBCP_IDLE);
    endfunction

    // ==========================================================
    // outputs; an enable high pulls the line low
    // ==========================================================
    logic talking;
    logic data_on;
    assign talking = is_talker(s_q.st);
    // data lines stay released until not-ready has been seen high
    assign data_on = is_talker(s_q.st) &&
                     ((s_q.st == gpibcp_pkg::GPIBCP_T_DAV) || (s_q.cnt != '0));

    assign tx_ready_o = (s_q.st == gpibcp_pkg::GPIBCP_IDLE) && !ifc_req_i && !reset_i;
    assign rx_valid_o = s_q.rxv;
    assign rx_data_o  = s_q.rxb;
    assign rx_end_o   = s_q.rxe;
    assign srq_o      = s_q.srq;
    assign busy_o     = (s_q.st != gpibcp_pkg::GPIBCP_IDLE);

    // one open-drain driver per data line; a one bit pulls its line low
    genvar bit_g;
    generate
        for (bit_g = 0; bit_g < gpibcp_pkg::DATA_W; bit_g = bit_g + 1) begin : g_dio
            assign dio_o[bit_g]    = 1'b0;
            assign dio_oe_o[bit_g] = data_on && s_q.txb[bit_g];
        end
    endgenerate

    assign dav_oe_o  = (s_q.st == gpibcp_pkg::GPIBCP_T_DAV);
    assign nrfd_oe_o = !frees_nrfd(s_q.st);
    assign ndac_oe_o = holds_ndac(s_q.st);
    assign eoi_oe_o  = (talking && s_q.txeoi && !s_q.atn) ||
                       (poll_i && s_q.st == gpibcp_pkg::GPIBCP_IDLE);
    assign atn_oe_o  = (talking && s_q.atn) ||
                       (poll_i && s_q.st == gpibcp_pkg::GPIBCP_IDLE);
    assign ifc_oe_o  = (s_q.st == gpibcp_pkg::GPIBCP_IFC);
    assign ren_oe_o  = remote_i;

endmodule

`default_nettype wire

// file: verif/gpibcp_port_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module gpibcp_port_asserts (
    input wire logic       clk_i,
    input wire logic       reset_i,
    input wire logic       tx_valid_i,
    input wire logic       tx_ready_o,
    input wire logic       tx_cmd_i,
    input wire logic       tx_end_i,
    input wire logic       dav_oe_o,
    input wire logic       ndac_i,
    input wire logic       nrfd_i,
    input wire logic       ifc_oe_o,
    input wire logic       atn_oe_o,
    input wire logic       eoi_oe_o,
    input wire logic       remote_i,
    input wire logic       ren_oe_o,
    input wire logic       poll_i,
    input wire logic       busy_o,
    input wire logic       srq_i,
    input wire logic       srq_o,
    input wire logic [7:0] tx_data_i,
    input wire logic [7:0] dio_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // ==============================
    // helper: length of clear pulse
    logic [11:0] ifc_cnt_q;
    always_ff @(posedge clk_i) begin
        ifc_cnt_q <= ifc_oe_o ? ifc_cnt_q + 12'h1 : 12'h0;
    end
    // byte most recently taken for sending
    logic [7:0] byte_q;
    always_ff @(posedge clk_i) begin
        if (tx_valid_i && tx_ready_o) begin
            byte_q <= tx_data_i;
        end
    end
    chk_dav_when_ready: assert property ($rose(dav_oe_o) |-> $past(nrfd_i))
        else $error("dav raised while nrfd low");
    chk_byte_on_lines: assert property (dav_oe_o |->
        busy_o && dio_oe_o == byte_q) else $error("byte not on lines");
    chk_data_after_nrfd: assert property (dio_oe_o != 8'h00 && !dav_oe_o |->
        $past(nrfd_i)) else $error("data driven before nrfd released");
    chk_eoi_on_end: assert property (tx_valid_i && tx_ready_o && !tx_cmd_i |=>
        eoi_oe_o == $past(tx_end_i)) else $error("end mark wrong");
    chk_cmd_sets_atn: assert property (tx_valid_i && tx_ready_o && tx_cmd_i |=>
        atn_oe_o [*8]) else $error("atn missing on command");
    chk_dav_drops: assert property (dav_oe_o && ndac_i |=>
        !dav_oe_o && dio_oe_o == 8'h00) else $error("dav held after accept");
    chk_data_held: assert property (dav_oe_o |-> $stable(dio_oe_o))
        else $error("data moved under dav");
    chk_ifc_length: assert property ($fell(ifc_oe_o) && !$past(reset_i) |->
        ifc_cnt_q == 12'h7d0) else $error("clear pulse length wrong");
    chk_ifc_no_atn: assert property (ifc_oe_o |-> !atn_oe_o && busy_o)
        else $error("atn during clear");
    chk_remote_line: assert property (ren_oe_o == remote_i)
        else $error("ren not following remote");
    chk_poll_lines: assert property (poll_i && !busy_o |-> atn_oe_o && eoi_oe_o)
        else $error("poll lines missing");
    chk_srq_report: assert property (!$past(reset_i) |-> srq_o == !$past(srq_i))
        else $error("srq not reported");
    cover property ($rose(dav_oe_o));
    cover property ($fell(ifc_oe_o));
    cover property (poll_i && !busy_o);
endmodule
bind gpibcp_port gpibcp_port_asserts chk_u (.clk_i, .reset_i, .tx_valid_i, .tx_ready_o,
    .tx_cmd_i, .tx_end_i, .dav_oe_o, .ndac_i, .nrfd_i, .ifc_oe_o, .atn_oe_o, .eoi_oe_o, .remote_i,
    .ren_oe_o, .poll_i, .busy_o, .srq_i, .srq_o, .tx_data_i, .dio_oe_o);
`default_nettype wire

// file: verif/gpibcp_instr.sv
`timescale 1ns/1ns
`default_nettype none
module gpibcp_instr (
    input  wire logic       clk_i, reset_i, talk_i, dav_i, nrfd_i, ndac_i,
    input  wire logic [3:0] stall_i,
    input  wire logic [7:0] byte_i, dio_i,
    output logic [7:0]      dio_oe_o, got_o,
    output logic            dav_oe_o, nrfd_oe_o, ndac_oe_o, eoi_oe_o
);
    logic [3:0] cnt_q;
    logic       ndac_q, drv_q, done_q;
    assign nrfd_oe_o = !talk_i && cnt_q != 4'h0;
    assign ndac_oe_o = !talk_i && ndac_q;
    assign dio_oe_o  = drv_q ? byte_i : 8'h00;
    assign eoi_oe_o  = dav_oe_o;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            {cnt_q, ndac_q, drv_q, done_q, dav_oe_o} <= {stall_i, 4'h8};
        end else if (talk_i) begin
            if (dav_oe_o && ndac_i) begin
                {drv_q, dav_oe_o, done_q} <= 3'h1;
            end else if (!done_q && nrfd_i && !ndac_i) begin
                drv_q    <= 1'b1;
                dav_oe_o <= drv_q;
            end
        end else begin
            {drv_q, dav_oe_o, done_q} <= 3'h0;
            if (!dav_i) begin
                got_o  <= ~dio_i;
                ndac_q <= 1'b0;
                cnt_q  <= stall_i;
            end else begin
                ndac_q <= 1'b1;
                cnt_q  <= cnt_q - 4'(cnt_q != 4'h0);
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic       clk_i = 0, reset_i = 1, tx_valid_i = 0, tx_cmd_i = 0, tx_end_i = 0;
    logic       rx_start_i = 0, rx_ready_i = 0, ifc_req_i = 0, remote_i = 0, poll_i = 0;
    logic       srq_i = 1, p_talk = 0, tx_ready_o, rx_valid_o, rx_end_o, srq_o, busy_o;
    logic       dav_oe_o, nrfd_oe_o, ndac_oe_o, eoi_oe_o, atn_oe_o, ifc_oe_o, ren_oe_o;
    logic       p_dav, p_nrfd, p_ndac, p_eoi, dav_i, nrfd_i, ndac_i, eoi_i;
    logic [7:0] tx_data_i = 0, p_byte = 0, rx_data_o, dio_o, dio_oe_o, p_dio, p_got, dio_i;
    int         errors = 0, samples_checked = 0, cyc = 0;
    // ==============================
    // open-drain lines with pull-ups
    assign dav_i  = ~(dav_oe_o | p_dav);
    assign nrfd_i = ~(nrfd_oe_o | p_nrfd);
    assign ndac_i = ~(ndac_oe_o | p_ndac);
    assign eoi_i  = ~(eoi_oe_o | p_eoi);
    assign dio_i  = ~(dio_oe_o | p_dio);
    gpibcp_port dut_u (.clk_i, .reset_i, .tx_valid_i, .tx_ready_o, .tx_data_i, .tx_cmd_i,
        .tx_end_i, .rx_start_i, .rx_valid_o, .rx_data_o, .rx_end_o, .rx_ready_i, .ifc_req_i,
        .remote_i, .poll_i, .srq_o, .busy_o, .dio_i, .dio_o, .dio_oe_o, .dav_i, .dav_oe_o,
        .nrfd_i, .nrfd_oe_o, .ndac_i, .ndac_oe_o, .eoi_i, .eoi_oe_o, .atn_oe_o, .ifc_oe_o,
        .ren_oe_o, .srq_i);
    gpibcp_instr peer_u (.clk_i, .reset_i, .talk_i(p_talk), .dav_i, .nrfd_i, .ndac_i,
        .stall_i(4'h5), .byte_i(p_byte), .dio_i, .dio_oe_o(p_dio), .got_o(p_got),
        .dav_oe_o(p_dav), .nrfd_oe_o(p_nrfd), .ndac_oe_o(p_ndac), .eoi_oe_o(p_eoi));
    task chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wait_idle();
        for (int i = 0; i < 3000 && busy_o !== 1'b0; i++) @(negedge clk_i);
        chk(16'(busy_o), 16'h0);
    endtask
    task t_talk(input logic [7:0] b, input logic c, input logic e);
        {tx_data_i, tx_cmd_i, tx_end_i, tx_valid_i} = {b, c, e, 1'b1};
        @(negedge clk_i);
        tx_valid_i = 0;
        wait_idle();
        chk(16'(p_got), 16'(b));
        chk(16'(dio_o), 16'h0);
    endtask
    task t_listen(input logic [7:0] b);
        {p_byte, p_talk, rx_start_i} = {b, 2'h3};
        @(negedge clk_i);
        rx_start_i = 0;
        for (int i = 0; i < 200 && rx_valid_o !== 1'b1; i++) @(negedge clk_i);
        chk({rx_end_o, rx_data_o}, {1'b1, b});
        rx_ready_i = 1;
        @(negedge clk_i);
        {rx_ready_i, p_talk} = 2'h0;
        chk(16'(rx_valid_o), 16'h0);
        wait_idle();
    endtask
    task t_ifc();
        int n;
        n = 0;
        ifc_req_i = 1;
        @(negedge clk_i);
        ifc_req_i = 0;
        for (int i = 0; i < 2100 && busy_o; i++) begin
            n += int'(ifc_oe_o);
            @(negedge clk_i);
        end
        chk(16'(n), 16'(gpibcp_pkg::IFC_CYC));
    endtask
    task t_misc(input logic v);
        {remote_i, poll_i, srq_i} = {v, v, !v};
        repeat (2) @(negedge clk_i);
        chk({ren_oe_o, atn_oe_o, eoi_oe_o, srq_o}, {4{v}});
    endtask
    task print_verdict();
        if (errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial forever #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (12) @(negedge clk_i);
        reset_i = 0;
        t_misc(1);
        t_misc(0);
        t_talk(8'h80, 0, 0);
        t_talk(8'h01, 1, 0);
        t_talk(8'h5a, 0, 1);
        t_listen(8'ha5);
        t_ifc();
        print_verdict();
    end
endmodule
`default_nettype wire
